//--- rtl/pxp_top.sv
// Parallel I/O expansion: four input ports, four strobed output ports
// Contract
// - Four 8-bit input ports readable by host
// - Input follows while strobe high, else holds
// - Static setting picks latched or live input
// - Four 8-bit output latches drive until rewritten
// - Every output write emits peripheral strobe
// - Strobe width 100/200/400/800/1600 ns selectable
// - Switches pick one of 64 base addresses
// - Four consecutive addresses; reads in, writes out
// - Data non-inverted, 8-bit word
`timescale 1ns/1ps
module pxp_top (
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic [5:0]  base_sel_i,
   input  wire logic [3:0]  in_latched_i,
   input  wire logic [2:0]  stb_width_i,
   input  wire logic [7:0]  bus_addr_i,
   input  wire logic        bus_rd_i,
   input  wire logic        bus_wr_i,
   input  wire logic [7:0]  bus_wdata_i,
   output logic      [7:0]  bus_rdata_o,
   output logic             bus_hit_o,
   input  wire logic [31:0] in_data_i,
   input  wire logic [3:0]  in_stb_i,
   output logic      [31:0] out_data_o,
   output logic      [3:0]  out_stb_o
);
   localparam int unsigned N = pxp_pkg::NUM_PORTS;
   localparam int unsigned W = pxp_pkg::PORT_W;
   localparam int unsigned CW = pxp_pkg::STB_CNT_W;

   typedef struct packed {
      logic [N*W-1:0] out;
      logic [N-1:0]   stb;
      logic [N*CW-1:0] cnt;
      logic [W-1:0]   rdata;
   } pxp_top_s;

   pxp_top_s q_r;
   pxp_top_s q_nxt;

   logic [N*W-1:0] in_rd;
   logic           hit;
   logic [1:0]     idx;
   logic [CW-1:0]  width_cyc;
   // Per-port write decode, read only by the checks at the end
   logic [N-1:0]   wr_hit;
   logic [N-1:0]   wr_none;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_in
         pxp_in_port #(.W(W)) u_in (
            .core_clk_i (core_clk_i),
            .srst_i     (srst_i),
            .pin_data_i (in_data_i[g*W +: W]),
            .pin_stb_i  (in_stb_i[g]),
            .latched_i  (in_latched_i[g]),
            .rd_data_o  (in_rd[g*W +: W])
         );
      end
   endgenerate

   // One base for all four ports; low two bits pick the port
   assign hit = (bus_addr_i[7:2] == base_sel_i);
   assign idx = bus_addr_i[1:0];
   assign bus_hit_o = hit & (bus_rd_i | bus_wr_i);

   always_comb begin
      case (pxp_pkg::pxp_width_e'(stb_width_i))
         pxp_pkg::PXP_W100:  width_cyc = CW'(pxp_pkg::STB_100_CYC);
         pxp_pkg::PXP_W200:  width_cyc = CW'(pxp_pkg::STB_200_CYC);
         pxp_pkg::PXP_W400:  width_cyc = CW'(pxp_pkg::STB_400_CYC);
         pxp_pkg::PXP_W800:  width_cyc = CW'(pxp_pkg::STB_800_CYC);
         pxp_pkg::PXP_W1600: width_cyc = CW'(pxp_pkg::STB_1600_CYC);
         default:            width_cyc = CW'(pxp_pkg::STB_1600_CYC);
      endcase
   end

   always_comb begin
      q_nxt = q_r;
      for (int i = 0; i < N; i++) begin
         if (q_r.cnt[i*CW +: CW] > CW'(1)) begin
            q_nxt.cnt[i*CW +: CW] = q_r.cnt[i*CW +: CW] - CW'(1);
         end else begin
            q_nxt.cnt[i*CW +: CW] = '0;
            q_nxt.stb[i] = 1'b0;
         end
         // A write during a running strobe restarts it at full width
         if (hit && bus_wr_i && (idx == 2'(i))) begin
            q_nxt.out[i*W +: W]   = bus_wdata_i;
            q_nxt.stb[i]          = 1'b1;
            q_nxt.cnt[i*CW +: CW] = width_cyc;
         end
      end
      // Reads return the selected input port unchanged
      if (hit && bus_rd_i) begin
         q_nxt.rdata = in_rd[idx*W +: W];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q_r.out   <= {N{pxp_pkg::OUT_RST}};
         q_r.stb   <= '0;
         q_r.cnt   <= '0;
         q_r.rdata <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign out_data_o  = q_r.out;
   assign out_stb_o   = q_r.stb;
   assign bus_rdata_o = q_r.rdata;
   assign wr_none     = ~wr_hit;

   a_wr_strobe: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (hit && bus_wr_i && idx == 2'h0) |=> out_stb_o[0])
      else $error("no strobe after write");

   a_wr_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (hit && bus_wr_i && idx == 2'h1) |=> (out_data_o[15:8] == $past(bus_wdata_i)))
      else $error("output latch missed write");

   a_out_keep: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !(hit && bus_wr_i) |=> $stable(out_data_o))
      else $error("output changed without write");

   // Strobe stands two cycles; a rewrite in between would restart it
   a_w100_len: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (hit && bus_wr_i && idx == 2'h2 && stb_width_i == 3'h0)
      ##1 !(hit && bus_wr_i && idx == 2'h2) ##1 !(hit && bus_wr_i && idx == 2'h2)
      |-> out_stb_o[2] ##1 !out_stb_o[2])
      else $error("100 ns strobe wrong length");

   a_w1600_len: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (hit && bus_wr_i && idx == 2'h3 && stb_width_i == 3'h4)
      |=> out_stb_o[3][*8])
      else $error("1600 ns strobe too short");

   // No disable here: these look at the edge just after reset was sampled
   a_rst_quiet: assert property (@(posedge core_clk_i)
      $past(srst_i) |-> (out_stb_o == 4'h0 && out_data_o == 32'h0))
      else $error("outputs not cleared by reset");

   a_rst_rdata: assert property (@(posedge core_clk_i)
      $past(srst_i) |-> (bus_rdata_o == 8'h00))
      else $error("read data not cleared by reset");

   // Accesses to another base must leave both directions untouched
   a_miss_ignored: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (bus_wr_i && bus_addr_i[7:2] != base_sel_i) |=> $stable(out_data_o))
      else $error("write outside base accepted");

   a_miss_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (bus_rd_i && bus_addr_i[7:2] != base_sel_i) |=> $stable(bus_rdata_o))
      else $error("read outside base accepted");

   a_rd_data: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (hit && bus_rd_i && idx == 2'h0) |=> (bus_rdata_o == $past(in_rd[7:0])))
      else $error("read returned wrong port");

   a_rdata_keep: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !(hit && bus_rd_i) |=> $stable(bus_rdata_o))
      else $error("read data changed without read");

   // Each port checked on its own; widths past eight cycles chain runs of eight
   generate
      for (g = 0; g < N; g++) begin : g_chk
         assign wr_hit[g] = hit & bus_wr_i & (idx == 2'(g));

         a_port_take: assert property (@(posedge core_clk_i) disable iff (srst_i)
            wr_hit[g] |=> (out_stb_o[g] && out_data_o[g*W +: W] == $past(bus_wdata_i)))
            else $error("port write not taken");

         a_port_keep: assert property (@(posedge core_clk_i) disable iff (srst_i)
            !wr_hit[g] |=> $stable(out_data_o[g*W +: W]))
            else $error("port output changed without write");

         a_stb_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (!out_stb_o[g] && !wr_hit[g]) |=> !out_stb_o[g])
            else $error("strobe rose without write");

         a_port_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (hit && bus_rd_i && idx == 2'(g)) |=> (bus_rdata_o == $past(in_rd[g*W +: W])))
            else $error("read returned wrong input byte");

         // Strobe is high for exactly the selected count, then falls
         a_len_w100: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (wr_hit[g] && stb_width_i == 3'h0) ##1 wr_none[g] [*2]
            |-> out_stb_o[g] ##1 !out_stb_o[g])
            else $error("port strobe not two cycles");

         a_len_w200: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (wr_hit[g] && stb_width_i == 3'h1) ##1 wr_none[g] [*4]
            |-> out_stb_o[g] ##1 !out_stb_o[g])
            else $error("port strobe not four cycles");

         a_len_w400: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (wr_hit[g] && stb_width_i == 3'h2) ##1 wr_none[g] [*8]
            |-> out_stb_o[g] ##1 !out_stb_o[g])
            else $error("port strobe not eight cycles");

         a_len_w800: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (wr_hit[g] && stb_width_i == 3'h3) ##1 wr_none[g] [*8]
            ##1 wr_none[g] [*8]
            |-> out_stb_o[g] ##1 !out_stb_o[g])
            else $error("port strobe not sixteen cycles");

         a_len_w1600: assert property (@(posedge core_clk_i) disable iff (srst_i)
            (wr_hit[g] && stb_width_i >= 3'h4) ##1 wr_none[g] [*8]
            ##1 wr_none[g] [*8] ##1 wr_none[g] [*8]
            ##1 wr_none[g] [*8]
            |-> out_stb_o[g] ##1 !out_stb_o[g])
            else $error("port strobe not thirty-two cycles");
      end
   endgenerate
endmodule

//--- common/pxp_pkg.sv
// Constants for the parallel I/O expansion ports
package pxp_pkg;
   localparam int unsigned NUM_PORTS      = 4;
   localparam int unsigned PORT_W         = 8;
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned BASE_SEL_W     = 6;
   localparam int unsigned CLK_PERIOD_NS  = 50;
   // Strobe widths as printed, in ns
   localparam int unsigned STB_100_NS     = 100;
   localparam int unsigned STB_200_NS     = 200;
   localparam int unsigned STB_400_NS     = 400;
   localparam int unsigned STB_800_NS     = 800;
   localparam int unsigned STB_1600_NS    = 1600;
   // Least widths round up to whole cycles
   localparam int unsigned STB_100_CYC    = (STB_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_200_CYC    = (STB_200_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_400_CYC    = (STB_400_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_800_CYC    = (STB_800_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_1600_CYC   = (STB_1600_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STB_CNT_W      = 6;
   localparam logic [PORT_W-1:0] OUT_RST  = 8'h00;
   // Strobe width selector codes
   typedef enum logic [2:0] {
      PXP_W100  = 3'h0,
      PXP_W200  = 3'h1,
      PXP_W400  = 3'h2,
      PXP_W800  = 3'h3,
      PXP_W1600 = 3'h4
   } pxp_width_e;
endpackage

//--- rtl/pxp_in_port.sv
// One strobed input port: pin sync plus latched or live capture
`timescale 1ns/1ps
module pxp_in_port #(
   parameter int unsigned W = 8
) (
   input  wire logic         core_clk_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] pin_data_i,
   input  wire logic         pin_stb_i,
   input  wire logic         latched_i,
   output logic      [W-1:0] rd_data_o
);
   typedef struct packed {
      logic [W-1:0] d1;
      logic [W-1:0] d2;
      logic [W-1:0] d3;
      logic         s1;
      logic         s2;
      logic         s3;
      logic [W-1:0] hold;
   } pxp_in_s;

   pxp_in_s q_r;
   pxp_in_s q_nxt;

   // Data and strobe go through three stages; hold takes a change once strobe stages 2 and 3 are high and data stages 2 and 3 agree
   always_comb begin
      q_nxt    = q_r;
      q_nxt.d1 = pin_data_i;
      q_nxt.d2 = q_r.d1;
      q_nxt.d3 = q_r.d2;
      q_nxt.s1 = pin_stb_i;
      q_nxt.s2 = q_r.s1;
      q_nxt.s3 = q_r.s2;
      if (q_r.s2 && q_r.s3 && (q_r.d2 == q_r.d3)) begin
         q_nxt.hold = q_r.d3;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Unlatched reads see the settled live lines
   assign rd_data_o = latched_i ? q_r.hold : q_r.d3;

   a_hold_steady: assert property (@(posedge core_clk_i) disable iff (srst_i)
      (!q_r.s2 && !q_r.s3 && !srst_i) |=> (q_r.hold == $past(q_r.hold)))
      else $error("input hold changed while strobe low");
endmodule

//--- tb/pxp_host.sv
// Host bus master model driving the expansion ports
`timescale 1ns/1ps
module pxp_host (
   input  wire logic       core_clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       hit_i,
   output logic      [7:0] addr_o,
   output logic            rd_o,
   output logic            wr_o,
   output logic      [7:0] wdata_o
);
   // Address decode seen during the last access, for the bench to judge
   logic hit_seen;
   initial begin
      hit_seen = 1'b0;
      addr_o  = 8'h00;
      wdata_o = 8'h00;
      rd_o    = 1'b0;
      wr_o    = 1'b0;
   end
   // One access per call; a write has w set, a read clear
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(posedge core_clk_i);
      #5;
      addr_o  = a;
      wdata_o = d;
      rd_o    = ~w;
      wr_o    = w;
      @(posedge core_clk_i);
      #1;
      q = rdata_i;
      hit_seen = hit_i;
      #4;
      // Idle bus shows inverted values so stale data never looks valid
      addr_o  = ~addr_o;
      wdata_o = ~wdata_o;
      rd_o    = 1'b0;
      wr_o    = 1'b0;
   endtask
endmodule

//--- tb/pxp_top_tb.sv
// Self-checking bench for the expansion ports
`timescale 1ns/1ps
module pxp_top_tb;
   logic        clk   = 1'b0;
   logic        srst  = 1'b1;
   logic [5:0]  base  = 6'h2A;
   logic [2:0]  wsel  = 3'h0;
   logic [31:0] in_d  = 32'h0;
   logic [3:0]  in_s  = 4'h0;
   logic [3:0]  lat   = 4'h5;
   wire  [7:0]  addr, wdata, rdata;
   wire         rd, wr, hit;
   wire  [31:0] out_d;
   wire  [3:0]  out_s;
   int          n_mismatch = 0;
   int          checks     = 0;
   always #25 clk = ~clk;
   pxp_host host_u (.core_clk_i(clk), .rdata_i(rdata), .hit_i(hit), .addr_o(addr), .rd_o(rd),
                    .wr_o(wr), .wdata_o(wdata));
   pxp_top dut_u (.core_clk_i(clk), .srst_i(srst), .base_sel_i(base), .in_latched_i(lat),
                  .stb_width_i(wsel), .bus_addr_i(addr), .bus_rd_i(rd), .bus_wr_i(wr),
                  .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_hit_o(hit),
                  .in_data_i(in_d), .in_stb_i(in_s), .out_data_o(out_d), .out_stb_o(out_s));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic t_reset();
      chk("out_data", 32'h0, out_d);
      repeat (3) @(posedge clk);
      #10;
      chk("out_stb", 32'h0, {28'h0, out_s});
      chk("rdata", 32'h0, {24'h0, rdata});
      $display("test reset done");
   endtask
   // Strobe counted over 40 cycles, longer than the widest setting; code 5 acts as the widest
   task automatic t_write();
      logic [7:0] q;
      int         n;
      for (int w = 0; w < 6; w++) begin
         @(posedge clk);
         #5 wsel = w[2:0];
         for (int k = 0; k < 4; k++) begin
            host_u.acc(1'b1, {base, k[1:0]}, 8'h3C + 8'(w * 4 + k), q);
            chk("wr_hit", 32'h1, {31'h0, host_u.hit_seen});
            n = 0;
            repeat (40) begin
               if (out_s[k] === 1'b1) n++;
               @(posedge clk);
               #10;
            end
            chk("stb_len", (w < 5) ? 32'(2 << w) : 32'h20, 32'(n));
            chk("out_byte", 32'h3C + 32'(w * 4 + k), {24'h0, out_d[8*k +: 8]});
         end
      end
      chk("out_all", 32'h53525150, out_d);
      $display("test write done");
   endtask
   // Ports whose bit is set in l are latched and return a; the others are live and return b
   task automatic t_read(input logic [3:0] l, input logic [31:0] a, input logic [31:0] b);
      logic [7:0]  q;
      logic [31:0] e;
      @(posedge clk);
      #5 lat = l;
      in_d = a;
      in_s = 4'hF;
      repeat (6) @(posedge clk);
      #5 in_s = 4'h0;
      repeat (6) @(posedge clk);
      #5 in_d = b;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 4; k++) begin
         host_u.acc(1'b0, {base, k[1:0]}, 8'h00, q);
         e = l[k] ? a : b;
         chk("in_byte", {24'h0, e[8*k +: 8]}, {24'h0, q});
         chk("rd_hit", 32'h1, {31'h0, host_u.hit_seen});
      end
      $display("test read done");
   endtask
   task automatic t_addr();
      logic [7:0] q;
      host_u.acc(1'b1, {~base, 2'h0}, 8'hFF, q);
      chk("miss", 32'h53525150, out_d);
      chk("miss_hit", 32'h0, {31'h0, host_u.hit_seen});
      host_u.acc(1'b0, {~base, 2'h1}, 8'h00, q);
      chk("miss_rd", 32'hC3, {24'h0, q});
      base = 6'h15;
      host_u.acc(1'b1, 8'h57, 8'h81, q);
      chk("new_base", 32'h81525150, out_d);
      chk("new_hit", 32'h1, {31'h0, host_u.hit_seen});
      $display("test addr done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #5 srst = 1'b0;
      t_reset();
      t_write();
      t_read(4'h5, 32'h88776655, 32'h11223344);
      t_read(4'hA, 32'hC3A55A3C, 32'h0F1E2D3C);
      t_addr();
      @(posedge clk);
      #5 srst = 1'b1;
      @(posedge clk);
      #5 srst = 1'b0;
      t_reset();
      close_out();
   end
   initial begin
      #500000;
      n_mismatch++;
      close_out();
   end
endmodule
